// ---- hw/tgio_map.svh ----
// Register offsets, field positions and reset values of the timer pin block
`ifndef TGIO_MAP_SVH
`define TGIO_MAP_SVH
`define TGIO_ADDR_W 6
`define TGIO_DATA_W 16
`define TGIO_NUM_GR 8
`define TGIO_NUM_CTRL 4
`define TGIO_OFS_CTRL_AB 6'h00
`define TGIO_OFS_CTRL_CD 6'h04
`define TGIO_OFS_CTRL_EF 6'h08
`define TGIO_OFS_CTRL_GH 6'h0c
`define TGIO_OFS_GR_BASE 6'h10
`define TGIO_OFS_GR_LAST 6'h2c
`define TGIO_OFS_PIN_STATE 6'h30
`define TGIO_CTRL_RESET 8'h00
`define TGIO_CTRL_MASK 8'h77
`define TGIO_FLD_HI_MSB 6
`define TGIO_FLD_HI_LSB 4
`define TGIO_FLD_LO_MSB 2
`define TGIO_FLD_LO_LSB 0
`define TGIO_GR_RESET 16'hffff
`define TGIO_PIN_RESET 8'h00
`endif

// ---- hw/tgio_pkg.sv ----
// Types shared by the timer pin function block
package tgio_pkg;
  typedef enum logic [2:0]
  {
    TGIO_OC_OFF = 3'b000,
    TGIO_OC_LOW = 3'b001,
    TGIO_OC_HIGH = 3'b010,
    TGIO_OC_TOGGLE = 3'b011,
    TGIO_IC_OFF = 3'b100,
    TGIO_IC_RISE = 3'b101,
    TGIO_IC_FALL = 3'b110,
    TGIO_IC_BOTH = 3'b111
  } tgio_func_t;

  typedef struct packed
  {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tgio_bus_req_t;

  typedef struct packed
  {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } tgio_pin_drv_t;
endpackage

// ---- hw/tgio_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tgio_sync
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  // Level moves only when the last two stages agree
  always_comb
  begin
    next_level = level;
    if (stage2 == stage3)
    begin
      next_level = stage3;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end
endmodule
`default_nettype wire

// ---- hw/tgio_top.sv ----
// Pin function control, general registers, capture and compare output
`timescale 1ns/100ps
`default_nettype none
`include "tgio_map.svh"

module tgio_top
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [`TGIO_ADDR_W-1:0] bus_addr,
  input wire logic [`TGIO_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`TGIO_DATA_W-1:0] bus_rdata,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [`TGIO_DATA_W-1:0] free_cnt,
  input wire logic cnt_tick,
  input wire logic [`TGIO_NUM_GR-1:0] timer_pin_in,
  output tgio_pkg::tgio_pin_drv_t timer_pin_drv,
  output logic [`TGIO_NUM_GR-1:0] capture_evt
);
  import tgio_pkg::*;

  tgio_bus_req_t req;
  logic standby;
  logic [7:0] ctrl [`TGIO_NUM_CTRL];
  logic [7:0] next_ctrl [`TGIO_NUM_CTRL];
  logic [`TGIO_DATA_W-1:0] gr [`TGIO_NUM_GR];
  logic [`TGIO_DATA_W-1:0] next_gr [`TGIO_NUM_GR];
  tgio_func_t func [`TGIO_NUM_GR];
  logic [`TGIO_NUM_GR-1:0] pin_lvl;
  logic [`TGIO_NUM_GR-1:0] pin_prev;
  logic [`TGIO_NUM_GR-1:0] pin_lvl_q;
  logic [`TGIO_NUM_GR-1:0] next_pin_lvl_q;
  logic [`TGIO_NUM_GR-1:0] rise;
  logic [`TGIO_NUM_GR-1:0] fall;
  logic [`TGIO_NUM_GR-1:0] cap_hit;
  logic [`TGIO_NUM_GR-1:0] next_capture_evt;
  logic [`TGIO_NUM_GR-1:0] match;
  logic [`TGIO_NUM_GR-1:0] drive_lvl;
  logic [`TGIO_NUM_GR-1:0] next_drive_lvl;
  logic [`TGIO_NUM_GR-1:0] drive_oe;
  logic [`TGIO_NUM_GR-1:0] next_drive_oe;
  logic [`TGIO_NUM_GR-1:0] wr_lock;
  logic [`TGIO_DATA_W-1:0] next_rdata;
  logic ctrl_sel;
  logic gr_sel;
  logic [1:0] ctrl_idx;
  logic [2:0] gr_idx;

  assign req.addr = bus_addr;
  assign req.wdata = bus_wdata;
  assign req.wr = bus_wr;
  assign req.rd = bus_rd;
  assign standby = hw_standby | sw_standby;

  // Address decode
  assign ctrl_sel = (req.addr[5:4] == 2'b00) && (req.addr[1:0] == 2'b00);
  assign ctrl_idx = req.addr[3:2];
  assign gr_sel = (req.addr >= `TGIO_OFS_GR_BASE) &&
                  (req.addr <= `TGIO_OFS_GR_LAST) &&
                  (req.addr[1:0] == 2'b00);
  assign gr_idx = 3'(req.addr[5:2] - 4'h4);

  genvar gi;
  generate
    for (gi = 0; gi < `TGIO_NUM_GR; gi++)
    begin : g_chan
      if (gi % 2 == 1)
      begin : g_hi
        assign func[gi] = tgio_func_t'(
          ctrl[gi/2][`TGIO_FLD_HI_MSB:`TGIO_FLD_HI_LSB]);
      end
      else
      begin : g_lo
        assign func[gi] = tgio_func_t'(
          ctrl[gi/2][`TGIO_FLD_LO_MSB:`TGIO_FLD_LO_LSB]);
      end

      tgio_sync u_sync
      (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(timer_pin_in[gi]),
        .level(pin_lvl[gi])
      );
    end
  endgenerate

  assign pin_prev = pin_lvl_q;
  assign next_pin_lvl_q = pin_lvl;
  assign rise = pin_lvl & ~pin_prev;
  assign fall = ~pin_lvl & pin_prev;

  // Edge selection and write lock per register
  always_comb
  begin
    cap_hit = '0;
    wr_lock = '0;
    match = '0;
    for (int i = 0; i < `TGIO_NUM_GR; i++)
    begin
      case (func[i])
        TGIO_IC_OFF:
        begin
          cap_hit[i] = 1'b0;
        end
        TGIO_IC_RISE:
        begin
          cap_hit[i] = rise[i];
          wr_lock[i] = 1'b1;
        end
        TGIO_IC_FALL:
        begin
          cap_hit[i] = fall[i];
          wr_lock[i] = 1'b1;
        end
        TGIO_IC_BOTH:
        begin
          cap_hit[i] = rise[i] | fall[i];
          wr_lock[i] = 1'b1;
        end
        TGIO_OC_OFF:
        begin
          match[i] = 1'b0;
        end
        default:
        begin
          match[i] = cnt_tick && (free_cnt == gr[i]);
        end
      endcase
    end
  end

  // Compare output level per register
  always_comb
  begin
    next_drive_lvl = drive_lvl;
    next_drive_oe = drive_oe;
    for (int i = 0; i < `TGIO_NUM_GR; i++)
    begin
      case (func[i])
        TGIO_OC_LOW:
        begin
          next_drive_oe[i] = 1'b1;
          if (match[i])
          begin
            next_drive_lvl[i] = 1'b0;
          end
        end
        TGIO_OC_HIGH:
        begin
          next_drive_oe[i] = 1'b1;
          if (match[i])
          begin
            next_drive_lvl[i] = 1'b1;
          end
        end
        TGIO_OC_TOGGLE:
        begin
          next_drive_oe[i] = 1'b1;
          if (match[i])
          begin
            next_drive_lvl[i] = ~drive_lvl[i];
          end
        end
        TGIO_OC_OFF:
        begin
          next_drive_oe[i] = 1'b0;
        end
        default:
        begin
          next_drive_oe[i] = 1'b0;
        end
      endcase
    end
  end

  // Control register update
  always_comb
  begin
    for (int k = 0; k < `TGIO_NUM_CTRL; k++)
    begin
      next_ctrl[k] = ctrl[k];
      if (standby)
      begin
        next_ctrl[k] = `TGIO_CTRL_RESET;
      end
      else if (req.wr && ctrl_sel && (ctrl_idx == 2'(k)))
      begin
        next_ctrl[k] = req.wdata[7:0] & `TGIO_CTRL_MASK;
      end
    end
  end

  // General register update
  always_comb
  begin
    next_capture_evt = '0;
    for (int i = 0; i < `TGIO_NUM_GR; i++)
    begin
      next_gr[i] = gr[i];
      if (cap_hit[i])
      begin
        next_gr[i] = free_cnt;
        next_capture_evt[i] = 1'b1;
      end
      else if (req.wr && gr_sel && (gr_idx == 3'(i)) && !wr_lock[i])
      begin
        next_gr[i] = req.wdata;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_comb
  begin
    next_rdata = '0;
    if (req.rd)
    begin
      if (ctrl_sel)
      begin
        next_rdata = {8'h00, ctrl[ctrl_idx] & `TGIO_CTRL_MASK};
      end
      else if (gr_sel)
      begin
        next_rdata = gr[gr_idx];
      end
      else if (req.addr == `TGIO_OFS_PIN_STATE)
      begin
        next_rdata = {8'h00, pin_lvl};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int k = 0; k < `TGIO_NUM_CTRL; k++)
      begin
        ctrl[k] <= `TGIO_CTRL_RESET;
      end
      for (int i = 0; i < `TGIO_NUM_GR; i++)
      begin
        gr[i] <= `TGIO_GR_RESET;
      end
      pin_lvl_q <= '0;
      drive_lvl <= `TGIO_PIN_RESET;
      drive_oe <= '0;
      capture_evt <= '0;
      bus_rdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      gr <= next_gr;
      pin_lvl_q <= next_pin_lvl_q;
      drive_lvl <= next_drive_lvl;
      drive_oe <= next_drive_oe;
      capture_evt <= next_capture_evt;
      bus_rdata <= next_rdata;
    end
  end

  assign timer_pin_drv = '{pin_out: drive_lvl,
                           pin_oe: drive_oe};
endmodule
`default_nettype wire

// ---- test/tgio_props.sv ----
// Concurrent checks on the timer pin block ports
`timescale 1ns/100ps
`default_nettype none
module tgio_props
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [5:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [7:0] timer_pin_in,
  input wire tgio_pkg::tgio_pin_drv_t timer_pin_drv,
  input wire logic [7:0] capture_evt
);
  import tgio_pkg::*;
  logic [2:0] code_a;
  logic [2:0] next_code_a;
  logic stby;
  assign stby = hw_standby | sw_standby;
  always_comb
  begin
    next_code_a = code_a;
    if (stby)
      next_code_a = 3'h0;
    else if (bus_wr && bus_addr == 6'h00)
      next_code_a = bus_wdata[2:0];
  end
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      code_a <= 3'h0;
    else
      code_a <= next_code_a;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_rsv_zero: assert property (
    $past(bus_rd) && $past(bus_addr) < 6'h10
    |-> (bus_rdata & 16'hff88) == 16'h0000) else $error("reserved bits");
  a_stby_clear: assert property (
    $past(bus_rd) && $past(bus_addr) < 6'h10 && $past(stby) && $past(stby, 2)
    |-> bus_rdata == 16'h0000) else $error("standby read");
  a_ctrl_readback: assert property (
    $past(bus_rd) && $past(bus_addr) == 6'h00 && !$past(stby)
    |-> bus_rdata[2:0] == $past(code_a)) else $error("field a read");
  a_oe_code: assert property (
    !stby && $stable(code_a) |=> timer_pin_drv.pin_oe[0] ==
    ($past(code_a) inside {3'h1, 3'h2, 3'h3})) else $error("pin enable");
  a_rise_cap: assert property (
    code_a == 3'h5 && $rose(timer_pin_in[0])
    |-> ##[2:6] capture_evt[0]) else $error("rise capture");
  a_fall_ignored: assert property (
    code_a == 3'h5 && $fell(timer_pin_in[0])
    |=> (!capture_evt[0]) [*6]) else $error("fall captured");
  a_both_cap: assert property (
    code_a == 3'h7 && $changed(timer_pin_in[0])
    |-> ##[2:6] capture_evt[0]) else $error("both capture");
  a_off_no_cap: assert property (
    !code_a[2] || code_a == 3'h4 |=> !capture_evt[0]) else $error("capture");
  cover property (capture_evt[0]);
  cover property (timer_pin_drv.pin_oe[0] && timer_pin_drv.pin_out[0]);
  cover property (stby ##1 bus_rd);
endmodule
`default_nettype wire

// ---- test/tgio_pin_model.sv ----
// Signal sources and loads on the timer pins
`timescale 1ns/100ps
`default_nettype none
module tgio_pin_model
(
  input wire logic [7:0] pin_src,
  input wire tgio_pkg::tgio_pin_drv_t timer_pin_drv,
  output logic [7:0] timer_pin_in
);
  import tgio_pkg::*;
  // Driven pins show the block level, others the source
  assign timer_pin_in = (timer_pin_drv.pin_oe & timer_pin_drv.pin_out)
    | (~timer_pin_drv.pin_oe & pin_src);
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the timer pin block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tgio_pkg::*;
  logic ref_clk, rst_b, bus_wr, bus_rd, hw_standby, sw_standby, cnt_tick;
  logic [5:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, free_cnt, gexp;
  logic [7:0] pin_src, timer_pin_in, capture_evt;
  tgio_pin_drv_t timer_pin_drv;
  int bad_count, comparisons;
  tgio_top i_tgio_top (.ref_clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .hw_standby, .sw_standby, .free_cnt, .cnt_tick,
    .timer_pin_in, .timer_pin_drv, .capture_evt);
  tgio_pin_model i_tgio_pin_model (.pin_src, .timer_pin_drv, .timer_pin_in);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [5:0] a, logic [15:0] e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk("rdata", e, bus_rdata);
    @(posedge ref_clk);
  endtask
  task automatic tick(logic [15:0] v, logic e);
    free_cnt <= v;
    cnt_tick <= 1'b1;
    @(posedge ref_clk);
    cnt_tick <= 1'b0;
    #1;
    chk("pin_out", 16'(e), 16'(timer_pin_drv.pin_out[0]));
    @(posedge ref_clk);
  endtask
  task automatic cap(logic [2:0] c, logic lvl, logic [15:0] v, logic hit);
    int n = 0;
    wr(6'h00, 16'(c));
    wr(6'h10, 16'h0abc);
    if (c inside {3'h0, 3'h4})
      gexp = 16'h0abc;
    free_cnt <= v;
    pin_src[0] <= lvl;
    repeat (8)
    begin
      @(posedge ref_clk);
      if (capture_evt[0] === 1'b1)
        n++;
    end
    if (hit)
      gexp = v;
    chk("captures", 16'(hit), 16'(n));
    rd(6'h10, gexp);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      rd(6'(4 * i), 16'h0000);
      wr(6'(4 * i), 16'hff77);
      rd(6'(4 * i), 16'h0077);
    end
    rd(6'h3c, 16'h0000);
  endtask
  task automatic t_stby;
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    wr(6'h00, 16'h0011);
    rd(6'h04, 16'h0000);
    hw_standby <= 1'b0;
    sw_standby <= 1'b1;
    @(posedge ref_clk);
    rd(6'h08, 16'h0000);
    sw_standby <= 1'b0;
    @(posedge ref_clk);
    rd(6'h00, 16'h0000);
  endtask
  task automatic t_cmp;
    logic [2:0] codes [4] = '{3'h2, 3'h1, 3'h3, 3'h3};
    wr(6'h10, 16'h0005);
    tick(16'h0005, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h00, 16'(codes[i]));
      tick(16'h0005, ~i[0]);
    end
  endtask
  task automatic t_cap;
    logic [2:0] codes [8] = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7, 3'h4, 3'h0};
    logic [7:0] hits = 8'h39;
    gexp = 16'h0005;
    for (int i = 0; i < 8; i++)
      cap(codes[i], ~i[0], 16'h1111 * 16'(i + 1), hits[i]);
  endtask
  task automatic t_hi;
    int n = 0;
    wr(6'h04, 16'h0020);
    #1;
    chk("pin_oe", 16'h0008, 16'(timer_pin_drv.pin_oe));
    @(posedge ref_clk);
    wr(6'h0c, 16'h0050);
    wr(6'h2c, 16'h0123);
    free_cnt <= 16'h0777;
    pin_src[7] <= 1'b1;
    repeat (8)
    begin
      @(posedge ref_clk);
      if (capture_evt === 8'h80)
        n++;
    end
    chk("captures_h", 16'h0001, 16'(n));
    rd(6'h30, 16'h0080);
    rd(6'h2c, 16'h0777);
  endtask
  initial
  begin
    rst_b = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 6'h00;
    bus_wdata = 16'h0000;
    hw_standby = 1'b0;
    sw_standby = 1'b0;
    cnt_tick = 1'b0;
    free_cnt = 16'h0000;
    pin_src = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_stby;
    t_cmp;
    t_cap;
    t_hi;
    conclude;
  end
  initial
  begin
    #100us;
    bad_count++;
    conclude;
  end
endmodule
bind tgio_top tgio_props i_tgio_props (.ref_clk, .rst_b, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .hw_standby, .sw_standby,
  .timer_pin_in, .timer_pin_drv, .capture_evt);
`default_nettype wire
